// ### hw/hfs_pkg.sv
package hfs_pkg;

  // Timebase
  localparam int unsigned MCLK_HZ      = 20_000_000;
  localparam int unsigned FRAME_CLK_HZ = 790;
  localparam int unsigned MCLK_NS      = 50;

  // Printed times, in nanoseconds
  localparam int unsigned SHORT_BLANK_NS = 8_000;
  localparam int unsigned LEAD_NS        = 3_000;
  localparam int unsigned LONG_BLANK_NS  = 300_000;
  localparam int unsigned RAMP_RESET_NS  = 6_000;

  // Cycle counts derived from the times; least times round up
  localparam int unsigned PERIOD_CYC      = MCLK_HZ / FRAME_CLK_HZ;
  localparam int unsigned SHORT_BLANK_CYC =
    (SHORT_BLANK_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int unsigned LEAD_CYC        = (LEAD_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int unsigned LONG_BLANK_CYC  =
    (LONG_BLANK_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int unsigned RAMP_RESET_CYC  =
    (RAMP_RESET_NS + MCLK_NS - 1) / MCLK_NS;

  // Frame layout, zero-based cycle numbers
  localparam int unsigned FRAME_CYCLES   = 24;
  localparam logic [4:0]  CYC_LAST       = 5'h17;
  localparam logic [4:0]  CYC_RESET      = 5'h00;
  localparam logic [4:0]  CYC_DECK_FIRST = 5'h00;
  localparam logic [4:0]  CYC_AIR_FIRST  = 5'h02;
  localparam logic [4:0]  CYC_SYM_FIRST  = 5'h04;
  localparam logic [4:0]  CYC_RNG_FIRST  = 5'h08;

  // Beam anchor of each item, 8-bit deflection codes
  localparam logic [7:0] DECK_X = 8'h20;
  localparam logic [7:0] DECK_Y = 8'hC0;
  localparam logic [7:0] AIR_X  = 8'hE0;
  localparam logic [7:0] AIR_Y  = 8'h80;
  localparam logic [7:0] SYM_X  = 8'h80;
  localparam logic [7:0] SYM_Y  = 8'h80;
  localparam logic [7:0] RNG_X  = 8'h80;
  localparam logic [7:0] RNG_Y  = 8'hF0;

  // Display item, one-hot
  typedef enum logic [3:0] {
    ITEM_DECK  = 4'h1,
    ITEM_AIR   = 4'h2,
    ITEM_SYM   = 4'h4,
    ITEM_RANGE = 4'h8
  } hfs_item_t;

endpackage : hfs_pkg

// ### hw/hfs_phase_gen.sv
`timescale 1ns/1ps
module hfs_phase_gen #(
  parameter int unsigned PERIOD = hfs_pkg::PERIOD_CYC,
  parameter int unsigned PW     = $clog2(PERIOD)
) (
  // Clock and reset
  input  wire logic          mclk_in,
  input  wire logic          rst_b_in,
  // Phase within one display clock cycle
  output logic [PW-1:0]      phase_out,
  output logic               wrap_out
);

  localparam logic [PW-1:0] PH_LAST = PW'(PERIOD - 1);

  logic [PW-1:0] phase;

  // Free running; never gated
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      phase <= '0;
    end else if (phase == PH_LAST) begin
      phase <= '0;
    end else begin
      phase <= phase + PW'(1);
    end
  end

  assign phase_out = phase;
  assign wrap_out  = (phase == PH_LAST);

endmodule : hfs_phase_gen

// ### hw/hfs_frame_sequencer.sv
`timescale 1ns/1ps
module hfs_frame_sequencer #(
  parameter int unsigned PERIOD_CYC = hfs_pkg::PERIOD_CYC,
  parameter int unsigned LONG_CYC   = hfs_pkg::LONG_BLANK_CYC
) (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  // Timing to the display synthesizer
  output logic            frame_clk_out,
  output logic [4:0]      cycle_count_out,
  output logic [7:0]      gate_out,
  output logic [3:0]      item_sel_out,
  output logic            ramp_reset_out,
  // Tube drive
  output logic [7:0]      x_defl_out,
  output logic [7:0]      y_defl_out,
  output logic            blank_out
);

  localparam int unsigned PW = $clog2(PERIOD_CYC);
  localparam logic [PW-1:0] HALF      = PW'(PERIOD_CYC / 2);
  localparam logic [PW-1:0] LEAD_AT   =
    PW'(PERIOD_CYC - hfs_pkg::LEAD_CYC);
  localparam logic [PW-1:0] SHORT_END =
    PW'(hfs_pkg::SHORT_BLANK_CYC - hfs_pkg::LEAD_CYC);
  localparam logic [PW-1:0] LONG_END  = PW'(LONG_CYC);
  localparam logic [PW-1:0] RAMP_W    = PW'(hfs_pkg::RAMP_RESET_CYC);

  function automatic hfs_pkg::hfs_item_t item_of(input logic [4:0] c);
    if (c < hfs_pkg::CYC_AIR_FIRST) begin
      item_of = hfs_pkg::ITEM_DECK;
    end else if (c < hfs_pkg::CYC_SYM_FIRST) begin
      item_of = hfs_pkg::ITEM_AIR;
    end else if (c < hfs_pkg::CYC_RNG_FIRST) begin
      item_of = hfs_pkg::ITEM_SYM;
    end else begin
      item_of = hfs_pkg::ITEM_RANGE;
    end
  endfunction : item_of

  // Gate decode; reset and advance must agree on cycle 0
  function automatic logic [7:0] gate_of(input logic [4:0] c);
    if (c < hfs_pkg::CYC_RNG_FIRST) begin
      gate_of = 8'h01 << c[2:0];
    end else begin
      gate_of = 8'h00;
    end
  endfunction : gate_of

  logic [PW-1:0]       phase;
  logic                wrap;
  logic [4:0]          cyc;
  logic [4:0]          next_cyc;
  hfs_pkg::hfs_item_t  item;
  logic                next_blank;
  logic                short_blank;
  logic                jump_blank;
  logic                ramp_at_fall;
  logic                ramp_at_rise;

  // Phase zero is the counter advance; one display clock period
  hfs_phase_gen #(
    .PERIOD    (PERIOD_CYC),
    .PW        (PW)
  ) u_phase (
    .mclk_in   (mclk_in),
    .rst_b_in  (rst_b_in),
    .phase_out (phase),
    .wrap_out  (wrap)
  );

  // Reset only sets a start point; the count never pauses afterwards
  assign next_cyc = (cyc == hfs_pkg::CYC_LAST) ? hfs_pkg::CYC_RESET
                                               : cyc + 5'h01;

  // Advance falls LEAD cycles after the short blank began
  // Count and item share the wrap edge, so they never disagree
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      cyc <= hfs_pkg::CYC_RESET;
    end else if (wrap) begin
      cyc <= next_cyc;
    end
  end

  // Item follows the next count so both change on one edge
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      item <= hfs_pkg::ITEM_DECK;
    end else if (wrap) begin
      item <= item_of(next_cyc);
    end
  end

  // Low first half, so the wave falls at every advance, count 0 included
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      frame_clk_out <= 1'b0;
    end else begin
      frame_clk_out <= (phase >= HALF) && !wrap;
    end
  end

  // Short blank straddles each advance to hide local jumps
  // Early start covers the slow path to the tube
  assign short_blank = (phase >= LEAD_AT) || (phase < SHORT_END);

  // Long blank gives the coils time for the big move
  always_comb begin
    jump_blank = 1'b0;
    if ((cyc == hfs_pkg::CYC_DECK_FIRST) ||
        (cyc == hfs_pkg::CYC_AIR_FIRST) ||
        (cyc == hfs_pkg::CYC_SYM_FIRST)) begin
      jump_blank = (phase < HALF);
    end else if (cyc == hfs_pkg::CYC_RNG_FIRST) begin
      jump_blank = (phase < LONG_END);
    end
  end

  // Either source darkens the beam
  assign next_blank = short_blank || jump_blank;

  // One register stage keeps blank aligned with the registered deflection outputs
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      blank_out <= 1'b1;
    end else begin
      blank_out <= next_blank;
    end
  end

  // Ramp reset on both edges of the timing wave
  // Double rate, so the ramp restarts for each half-cycle stroke
  assign ramp_at_fall = (phase < RAMP_W);
  assign ramp_at_rise = (phase >= HALF) && (phase < HALF + RAMP_W);

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      ramp_reset_out <= 1'b0;
    end else begin
      ramp_reset_out <= ramp_at_fall || ramp_at_rise;
    end
  end

  // Gates for the first eight cycles, all low over the range circle
  // Reset shows the cycle 0 gate, as the decode would
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      gate_out <= gate_of(hfs_pkg::CYC_RESET);
    end else if (wrap) begin
      gate_out <= gate_of(next_cyc);
    end
  end

  // Item anchors steer the deflection amplifier
  // X and Y kept apart so each axis can be retimed alone
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      x_defl_out <= hfs_pkg::DECK_X;
    end else begin
      unique case (item)
        hfs_pkg::ITEM_DECK: begin
          x_defl_out <= hfs_pkg::DECK_X;
        end
        hfs_pkg::ITEM_AIR: begin
          x_defl_out <= hfs_pkg::AIR_X;
        end
        hfs_pkg::ITEM_SYM: begin
          x_defl_out <= hfs_pkg::SYM_X;
        end
        hfs_pkg::ITEM_RANGE: begin
          x_defl_out <= hfs_pkg::RNG_X;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      y_defl_out <= hfs_pkg::DECK_Y;
    end else begin
      unique case (item)
        hfs_pkg::ITEM_DECK: begin
          y_defl_out <= hfs_pkg::DECK_Y;
        end
        hfs_pkg::ITEM_AIR: begin
          y_defl_out <= hfs_pkg::AIR_Y;
        end
        hfs_pkg::ITEM_SYM: begin
          y_defl_out <= hfs_pkg::SYM_Y;
        end
        hfs_pkg::ITEM_RANGE: begin
          y_defl_out <= hfs_pkg::RNG_Y;
        end
      endcase
    end
  end

  assign cycle_count_out = cyc;
  assign item_sel_out    = item;

endmodule : hfs_frame_sequencer

// ### verif/hfs_seq_sva.sv
`timescale 1ns/1ps
module hfs_seq_sva (
  input wire logic       mclk_in,
  input wire logic       rst_b_in,
  input wire logic       frame_clk_out,
  input wire logic [4:0] cycle_count_out,
  input wire logic [7:0] gate_out,
  input wire logic [3:0] item_sel_out,
  input wire logic       blank_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  logic [4:0] c;
  assign c = cycle_count_out;
  a_count_wrap: assert property ($changed(c) |->
    c == ($past(c) == 5'h17 ? 5'h00 : $past(c) + 5'h01))
    else $error("frame count skipped");
  a_item_order: assert property (item_sel_out ==
    (c < 5'h02 ? 4'h1 : c < 5'h04 ? 4'h2 : c < 5'h08 ? 4'h4 : 4'h8))
    else $error("wrong item for count");
  a_gate_decode: assert property (
    gate_out == (c < 5'h08 ? 8'h01 << c : 8'h00))
    else $error("gate decode wrong");
  a_blank_jump: assert property ($changed(item_sel_out) |-> blank_out)
    else $error("item changed while lit");
  a_blank_lead: assert property ($changed(c) |-> $past(blank_out))
    else $error("count moved before blank");
  a_wave_fall: assert property ($changed(c) |->
    $fell(frame_clk_out))
    else $error("wave not falling at advance");
  a_half_blank: assert property (
    $changed(c) && c inside {5'h00, 5'h02, 5'h04} |-> ##150 blank_out)
    else $error("first half not blanked");
  a_long_blank: assert property ($changed(c) && c == 5'h08 |->
    ##250 blank_out)
    else $error("long blank too short");
  cover property ($rose(item_sel_out[3]));
  cover property ($fell(frame_clk_out));
  cover property (c == 5'h17 ##[1:400] c == 5'h00);
endmodule : hfs_seq_sva

bind hfs_frame_sequencer hfs_seq_sva u_sva (.mclk_in(mclk_in),
  .rst_b_in(rst_b_in), .frame_clk_out(frame_clk_out),
  .cycle_count_out(cycle_count_out), .gate_out(gate_out),
  .item_sel_out(item_sel_out), .blank_out(blank_out));

// ### verif/hfs_crt_model.sv
`timescale 1ns/1ps
// Beam spot; flags any visible jump since the tube would show a streak
module hfs_crt_model (
  input  wire logic       mclk_in,
  input  wire logic [7:0] x_in,
  input  wire logic [7:0] y_in,
  input  wire logic       blank_in,
  output logic [7:0]      pos_x_out,
  output logic [7:0]      pos_y_out,
  output logic            streak_out
);
  logic lit = 1'b0;
  logic streak = 1'b0;
  assign streak_out = streak;
  always @(posedge mclk_in) begin
    lit <= !blank_in;
    if (!blank_in) begin
      pos_x_out <= x_in;
      pos_y_out <= y_in;
      if (lit && (x_in !== pos_x_out || y_in !== pos_y_out))
        streak <= 1'b1;
    end
  end
endmodule : hfs_crt_model

// ### verif/hfs_frame_sequencer_bench.sv
`timescale 1ns/1ps
module hfs_frame_sequencer_bench;
  logic       mclk_in = 1'b0;
  logic       rst_b_in = 1'b0;
  logic       wave, blank, streak, ramp;
  logic [4:0] count;
  logic [3:0] item;
  logic [7:0] gate, xd, yd, pos_x, pos_y;
  logic [4:0] exp_c = 5'h00;
  int         n_errors = 0;
  int         n_compared = 0;
  always #25 mclk_in = ~mclk_in;
  // Short period keeps the run small
  hfs_frame_sequencer #(.PERIOD_CYC(400), .LONG_CYC(300)) dut (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .frame_clk_out(wave),
    .cycle_count_out(count), .gate_out(gate), .item_sel_out(item),
    .ramp_reset_out(ramp), .x_defl_out(xd), .y_defl_out(yd),
    .blank_out(blank));
  hfs_crt_model crt (.mclk_in(mclk_in), .x_in(xd), .y_in(yd),
    .blank_in(blank), .pos_x_out(pos_x), .pos_y_out(pos_y),
    .streak_out(streak));
  task automatic cmp(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task automatic run_cycles(input int n);
    int         k;
    logic [3:0] it;
    logic [7:0] ax, ay, hb;
    for (int i = 0; i < n; i++) begin
      k = 0;
      while (count === exp_c && k < 500) begin
        @(negedge mclk_in);
        k++;
      end
      exp_c = (exp_c == 5'h17) ? 5'h00 : exp_c + 5'h01;
      it = exp_c < 5'h02 ? 4'h1 : exp_c < 5'h04 ? 4'h2 :
           exp_c < 5'h08 ? 4'h4 : 4'h8;
      ax = it[0] ? hfs_pkg::DECK_X : it[1] ? hfs_pkg::AIR_X :
           it[2] ? hfs_pkg::SYM_X : hfs_pkg::RNG_X;
      ay = it[0] ? hfs_pkg::DECK_Y : it[1] ? hfs_pkg::AIR_Y :
           it[2] ? hfs_pkg::SYM_Y : hfs_pkg::RNG_Y;
      hb = {7'h0, exp_c inside {0, 2, 4, 8}};
      cmp("count", {3'h0, exp_c}, {3'h0, count});
      cmp("item", {4'h0, it}, {4'h0, item});
      cmp("gate", exp_c < 5'h08 ? 8'h01 << exp_c : 8'h00, gate);
      repeat (50) @(negedge mclk_in);
      cmp("blank_short", 8'h01, {7'h0, blank});
      cmp("ramp_fall", 8'h01, {7'h0, ramp});
      repeat (100) @(negedge mclk_in);
      cmp("blank_half", hb, {7'h0, blank});
      cmp("ramp_gap", 8'h00, {7'h0, ramp});
      repeat (100) @(negedge mclk_in);
      cmp("blank_long", {7'h0, exp_c == 5'h08}, {7'h0, blank});
      cmp("ramp_rise", 8'h01, {7'h0, ramp});
      repeat (80) @(negedge mclk_in);
      cmp("blank_off", 8'h00, {7'h0, blank});
      cmp("ramp_off", 8'h00, {7'h0, ramp});
      cmp("wave", 8'h01, {7'h0, wave});
      cmp("beam_x", ax, pos_x);
      cmp("beam_y", ay, pos_y);
    end
    cmp("streak", 8'h00, {7'h0, streak});
  endtask : run_cycles
  task automatic mid_reset();
    @(negedge mclk_in);
    rst_b_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    cmp("rst_count", 8'h00, {3'h0, count});
    cmp("rst_item", 8'h01, {4'h0, item});
    cmp("rst_blank", 8'h01, {7'h0, blank});
    cmp("rst_wave", 8'h00, {7'h0, wave});
    cmp("rst_gate", 8'h01, gate);
    cmp("rst_ramp", 8'h00, {7'h0, ramp});
    rst_b_in = 1'b1;
    exp_c = 5'h00;
  endtask : mid_reset
  task automatic close_out();
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  initial begin
    #(20000 * 50);
    n_errors++;
    close_out();
  end
  initial begin
    repeat (16) @(negedge mclk_in);
    rst_b_in = 1'b1;
    run_cycles(26);
    mid_reset();
    run_cycles(3);
    close_out();
  end
endmodule : hfs_frame_sequencer_bench
